/* rtl/adc_serial_pkg.sv */
// Purpose: Shared constants for the converter serial port and power control
// Assumes: 25 MHz system clock; serial clock idles high, frames of 16 clocks
// Notes:   Tagged rules follow
// Function
// R1: Two mode bits: normal, full, auto-off, standby
// R2: Chip select fall: convert, hold, drive output
// R3: Sixteen serial clocks per conversion and transfer
// R4: Back to track on 14th rising edge
// R5: Output released on 16th falling edge
// R6: Early chip select rise aborts, tristates output
// R7: Sample input on falls; three bits address
// R8: Control register loads on 15th fall
// R9: Range register loads on 11th fall
// R10: Registers change only when write bit set
// R11: Word: two zeros, channel, sign, result
// R12: First zero at select fall, second at fall one
// R13: Host waits quiet time before next conversion
// R14: Full shutdown on 15th rise, until rewritten
// R15: Normal write wakes from full shutdown, host waits
// R16: Auto shutdown on 15th rise, hold kept
// R17: Auto shutdown wakes on select rise, 500 us
// R18: Auto modes power down on 15th rise
// R19: Standby keeps reference; host sets reference bit
// R20: Standby wakes on select rise, 700 ns
// R21: Range write header and two bits per channel
// R22: Reference bit defaults external; first write invalid
// R23: Sign and result shift out MSB first
package adc_serial_pkg;
    localparam int CLK_NS        = 40;
    localparam int STBY_WAKE_NS  = 700;
    localparam int STBY_WAKE_CYC = (STBY_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int AUTO_WAKE_US  = 500;
    localparam int FULL_WAKE_US  = 500;
    localparam int NS_PER_US     = 1000;
    localparam int WAKE_W        = 14;

    localparam int CNT_W      = 5;
    localparam int FRAME_LEN  = 16;
    localparam int TRACK_RISE = 14;
    localparam int MODE_RISE  = 15;
    localparam int CTRL_FALL  = 15;
    localparam int RANGE_FALL = 11;
    localparam int OUT_W      = 16;
    localparam int RES_W      = 13;

    localparam logic WRITE_ON      = 1'b1;
    localparam logic ZERO_OK       = 1'b0;
    localparam logic SEL_CTRL      = 1'b0;
    localparam logic SEL_RANGE     = 1'b1;

    localparam int          CTRL_W       = 12;
    localparam logic [11:0] CTRL_RESET   = 12'h000;
    localparam int          CTRL_CHAN    = 9;
    localparam int          CTRL_PM_HI   = 5;
    localparam int          CTRL_PM_LO   = 4;
    localparam int          CTRL_REF     = 2;
    localparam int          RNG0_HI      = 7;
    localparam int          RNG0_LO      = 6;
    localparam int          RNG1_HI      = 3;
    localparam int          RNG1_LO      = 2;
    localparam logic [3:0]  RANGE_RESET  = 4'h0;

    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_STBY   = 2'h1;
    localparam logic [1:0] PM_AUTO   = 2'h2;
    localparam logic [1:0] PM_FULL   = 2'h3;

    typedef enum logic [2:0] {
        PWR_ON,
        PWR_FULL_OFF,
        PWR_AUTO_OFF,
        PWR_STANDBY,
        PWR_WAKING
    } pwr_state_type;
endpackage

/* rtl/bit_sync.sv */
// Purpose: Two-flop synchroniser for a vector of independent levels
// Assumes: Each bit is a level or a toggle, never a multi-bit word
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else if (ce_i)
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* rtl/change_detect.sv */
// Purpose: One-cycle pulse on every change of a synchronised vector
// Assumes: Input already synchronised to clock_i
// Notes:   Reset value of the history must match the source reset value
`timescale 1ns/1ps
`default_nettype none
module change_detect #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] pulse_o
);
    logic [WIDTH-1:0] prev_q;

    assign pulse_o = ce_i ? (level_i ^ prev_q) : '0;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prev_q <= INIT;
        else if (ce_i)
            prev_q <= level_i;
    end
endmodule
`default_nettype wire

/* rtl/adc_serial_power_control.sv */
// Purpose: Serial port and power-mode control of a two-channel converter
// Assumes: Serial clock idles high; chip select frames every transfer
// Notes:   Link logic runs on the serial clock, power logic on clock_i
`timescale 1ns/1ps
`default_nettype none
module adc_serial_power_control
    import adc_serial_pkg::*;
#(
    parameter int AUTO_WAKE_CYC = AUTO_WAKE_US * NS_PER_US / CLK_NS,
    parameter int FULL_WAKE_CYC = FULL_WAKE_US * NS_PER_US / CLK_NS
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    input  wire logic             sclk_i,
    input  wire logic             cs_n_i,
    input  wire logic             din_i,
    output logic                  dout_o,
    output logic                  dout_oe_o,
    input  wire logic [RES_W-1:0] conv_data_i,
    input  wire logic             conv_chan_i,
    output logic                  conv_start_o,
    output logic                  track_o,
    output logic                  power_down_o,
    output logic                  ref_on_o,
    output logic                  awake_o,
    output logic                  result_invalid_o,
    output logic                  power_mode_hi_o,
    output logic                  power_mode_lo_o,
    output logic                  ref_sel_o,
    output logic                  chan_sel_o,
    output logic                  chan0_range_hi_o,
    output logic                  chan0_range_lo_o,
    output logic                  chan1_range_hi_o,
    output logic                  chan1_range_lo_o
);
    // Link domain: serial clock, counters cleared while chip select is high
    logic              frame_rst;
    logic [CNT_W-1:0]  fall_cnt_q;
    logic [CNT_W-1:0]  fall_cnt_d;
    logic [CNT_W-1:0]  rise_cnt_q;
    logic [CNT_W-1:0]  rise_cnt_d;
    logic [OUT_W-1:0]  rx_q;
    logic [OUT_W-1:0]  rx_d;
    logic              released_q;
    logic              dout_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [3:0]        range_q;
    logic              tog_track_q;
    logic              tog_mode_q;
    logic              tog_range_q;
    logic              tog_done_q;

    // System domain results, held stable while a frame is running
    logic [RES_W-1:0]  result_q;
    logic              result_chan_q;

    assign frame_rst  = cs_n_i | ~rstn_i;
    assign fall_cnt_d = (fall_cnt_q == CNT_W'(FRAME_LEN)) ? fall_cnt_q
                                                          : fall_cnt_q + 1'b1;
    assign rise_cnt_d = (rise_cnt_q == CNT_W'(FRAME_LEN)) ? rise_cnt_q
                                                          : rise_cnt_q + 1'b1;
    assign rx_d       = {rx_q[OUT_W-2:0], din_i}; // [R7]

    wire       at_ctrl_fall  = (fall_cnt_d == CNT_W'(CTRL_FALL));
    wire       at_range_fall = (fall_cnt_d == CNT_W'(RANGE_FALL));
    wire       at_last_fall  = (fall_cnt_d == CNT_W'(FRAME_LEN));
    wire       at_track_rise = (rise_cnt_d == CNT_W'(TRACK_RISE));
    wire       at_mode_rise  = (rise_cnt_d == CNT_W'(MODE_RISE));

    // Header decode at the load edge of each register
    wire ctrl_hit  = (rx_d[CTRL_FALL-1] == WRITE_ON)
                   & (rx_d[CTRL_FALL-2] == ZERO_OK)
                   & (rx_d[CTRL_FALL-3] == SEL_CTRL); // [R7] [R10]
    wire range_hit = (rx_d[RANGE_FALL-1] == WRITE_ON)
                   & (rx_d[RANGE_FALL-2] == ZERO_OK)
                   & (rx_d[RANGE_FALL-3] == SEL_RANGE); // [R10] [R21]

    // Output word: zero, zero, channel, sign, result, MSB first
    wire [OUT_W-1:0] out_word = {2'b00, result_chan_q, result_q}; // [R11] [R23]
    wire [3:0]       out_idx  = 4'(OUT_W - 2) - fall_cnt_q[3:0];
    wire             out_bit  = out_word[out_idx];

    // Frame-scoped state on the falling edges
    always_ff @(negedge sclk_i or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            fall_cnt_q <= '0;
            rx_q       <= '0;
            dout_q     <= 1'b0; // [R12]
            released_q <= 1'b0; // [R6]
        end
        else
        begin
            fall_cnt_q <= fall_cnt_d;
            rx_q       <= rx_d;
            if (at_last_fall)
                released_q <= 1'b1; // [R5]
            else if (!released_q)
                dout_q <= out_bit; // [R12]
        end
    end

    // Registers written over the link survive between frames
    always_ff @(negedge sclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q      <= CTRL_RESET; // [R1] [R22]
            range_q     <= RANGE_RESET; // [R21]
            tog_range_q <= 1'b0;
            tog_done_q  <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            if (at_ctrl_fall && ctrl_hit)
                ctrl_q <= rx_d[CTRL_W-1:0]; // [R8]
            if (at_range_fall && range_hit)
            begin
                range_q     <= {rx_d[RNG1_HI], rx_d[RNG1_LO],
                                rx_d[RNG0_HI], rx_d[RNG0_LO]}; // [R9]
                tog_range_q <= ~tog_range_q;
            end
            if (at_last_fall && fall_cnt_q != CNT_W'(FRAME_LEN))
                tog_done_q <= ~tog_done_q; // [R3]
        end
    end

    always_ff @(posedge sclk_i or posedge frame_rst)
    begin
        if (frame_rst)
            rise_cnt_q <= '0;
        else
            rise_cnt_q <= rise_cnt_d;
    end

    always_ff @(posedge sclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tog_track_q <= 1'b0;
            tog_mode_q  <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            if (at_track_rise && rise_cnt_q != CNT_W'(TRACK_RISE))
                tog_track_q <= ~tog_track_q; // [R4]
            if (at_mode_rise && rise_cnt_q != CNT_W'(MODE_RISE))
                tog_mode_q <= ~tog_mode_q; // [R14] [R16] [R18]
        end
    end

    // Output is driven from chip select fall until released or aborted
    assign dout_o    = dout_q;
    assign dout_oe_o = ~cs_n_i & ~released_q; // [R2] [R6]

    // Crossing into the system clock
    logic [4:0] sync_lvl;
    logic [4:0] sync_evt;

    bit_sync #(
        .WIDTH   (5)
    ) u_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .async_i ({~cs_n_i, tog_track_q, tog_mode_q, tog_range_q, tog_done_q}),
        .sync_o  (sync_lvl)
    );

    change_detect #(
        .WIDTH   (5),
        .INIT    (5'h00)
    ) u_edges (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .level_i (sync_lvl),
        .pulse_o (sync_evt)
    );

    wire cs_fall   = sync_evt[4] &  sync_lvl[4];
    wire cs_rise   = sync_evt[4] & ~sync_lvl[4];
    wire evt_track = sync_evt[3];
    wire evt_mode  = sync_evt[2];
    wire evt_range = sync_evt[1];
    wire evt_done  = sync_evt[0];

    // Control word is stable here: it only changes at fall 15 of a frame
    wire [1:0] new_mode = {ctrl_q[CTRL_PM_HI], ctrl_q[CTRL_PM_LO]}; // [R1]
    wire       new_ref  = ctrl_q[CTRL_REF];

    // Power state machine
    pwr_state_type     state_q;
    pwr_state_type     state_d;
    logic [WAKE_W-1:0] wake_cnt_q;
    logic [WAKE_W-1:0] wake_cnt_d;
    logic              track_d;

    wire wake_done = (wake_cnt_q == '0);

    always_comb
    begin
        state_d    = state_q;
        wake_cnt_d = wake_done ? wake_cnt_q : wake_cnt_q - 1'b1;
        track_d    = track_o;
        if (cs_fall)
            track_d = 1'b0; // [R2]
        if (evt_track)
            track_d = 1'b1; // [R4]
        case (state_q)
            PWR_ON:
            begin
                if (cs_rise)
                    track_d = 1'b1; // [R6]
                if (evt_mode)
                begin
                    case (new_mode)
                        PM_FULL:
                            state_d = PWR_FULL_OFF; // [R14]
                        PM_AUTO:
                        begin
                            state_d = PWR_AUTO_OFF; // [R16] [R18]
                            track_d = 1'b0;
                        end
                        PM_STBY:
                        begin
                            state_d = PWR_STANDBY; // [R18] [R19]
                            track_d = 1'b0;
                        end
                        default:
                            state_d = PWR_ON;
                    endcase
                end
            end
            PWR_FULL_OFF:
            begin
                if (cs_rise)
                    track_d = 1'b1;
                if (evt_mode && new_mode != PM_FULL)
                begin
                    state_d    = PWR_WAKING; // [R15]
                    wake_cnt_d = WAKE_W'(FULL_WAKE_CYC);
                end
            end
            PWR_AUTO_OFF:
            begin
                if (cs_rise)
                begin
                    state_d    = PWR_WAKING; // [R17]
                    track_d    = 1'b1;
                    wake_cnt_d = WAKE_W'(AUTO_WAKE_CYC);
                end
                else if (evt_mode && new_mode == PM_FULL)
                    state_d = PWR_FULL_OFF;
            end
            PWR_STANDBY:
            begin
                if (cs_rise)
                begin
                    state_d    = PWR_WAKING; // [R20]
                    track_d    = 1'b1;
                    wake_cnt_d = WAKE_W'(STBY_WAKE_CYC);
                end
                else if (evt_mode && new_mode == PM_FULL)
                    state_d = PWR_FULL_OFF;
            end
            PWR_WAKING:
            begin
                if (cs_rise)
                    track_d = 1'b1;
                if (evt_mode && new_mode == PM_FULL)
                    state_d = PWR_FULL_OFF;
                else if (wake_done)
                    state_d = PWR_ON;
            end
            default:
                state_d = PWR_ON;
        endcase
    end

    logic ref_new_q;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= PWR_ON; // [R1]
            wake_cnt_q <= '0;
            track_o    <= 1'b1;
        end
        else if (ce_i)
        begin
            state_q    <= state_d;
            wake_cnt_q <= wake_cnt_d;
            track_o    <= track_d;
        end
    end

    // Status outputs and copies of the link registers
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            conv_start_o     <= 1'b0;
            power_down_o     <= 1'b0;
            ref_on_o         <= 1'b0;
            awake_o          <= 1'b1;
            power_mode_hi_o  <= 1'b0;
            power_mode_lo_o  <= 1'b0;
            ref_sel_o        <= 1'b0; // [R22]
            chan_sel_o       <= 1'b0;
            ref_new_q        <= 1'b0;
            result_invalid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            conv_start_o <= cs_fall; // [R2]
            power_down_o <= (state_d == PWR_FULL_OFF) | (state_d == PWR_AUTO_OFF)
                          | (state_d == PWR_STANDBY);
            ref_on_o     <= ref_sel_o & (state_d != PWR_FULL_OFF)
                          & (state_d != PWR_AUTO_OFF); // [R19]
            awake_o      <= (state_d == PWR_ON);
            if (evt_mode)
            begin
                power_mode_hi_o <= new_mode[1];
                power_mode_lo_o <= new_mode[0];
                ref_sel_o       <= new_ref;
                chan_sel_o      <= ctrl_q[CTRL_CHAN];
                ref_new_q       <= new_ref & ~ref_sel_o; // [R22]
            end
            if (evt_done)
            begin
                result_invalid_o <= evt_mode ? (new_ref & ~ref_sel_o) : ref_new_q; // [R22]
                ref_new_q        <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            result_q         <= '0;
            result_chan_q    <= 1'b0;
            chan0_range_hi_o <= RANGE_RESET[1];
            chan0_range_lo_o <= RANGE_RESET[0];
            chan1_range_hi_o <= RANGE_RESET[3];
            chan1_range_lo_o <= RANGE_RESET[2];
        end
        else if (ce_i)
        begin
            if (evt_done)
            begin
                result_q      <= conv_data_i; // [R13]
                result_chan_q <= conv_chan_i;
            end
            if (evt_range)
            begin
                chan0_range_hi_o <= range_q[1]; // [R21]
                chan0_range_lo_o <= range_q[0];
                chan1_range_hi_o <= range_q[3];
                chan1_range_lo_o <= range_q[2];
            end
        end
    end
endmodule
`default_nettype wire

/* dv/adc_serial_checker_properties.sv */
// Purpose: Timing properties of the converter serial port and power control
// Assumes: Serial clock idles high between frames
// Notes:   Fall counter tracks the position within a frame
`timescale 1ns/1ps
`default_nettype none
module adc_serial_checker (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic conv_start_o,
    input wire logic track_o,
    input wire logic power_down_o,
    input wire logic ref_on_o,
    input wire logic awake_o,
    input wire logic ref_sel_o
);
    logic [4:0] fall_q;
    always_ff @(negedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            fall_q <= 5'h00;
        else if (fall_q != 5'h1F)
            fall_q <= fall_q + 5'h01;
    end
    property link_p(logic a, logic b);
        @(negedge sclk_i) disable iff (!rstn_i || cs_n_i) a |-> b;
    endproperty
    oe_frame_a: assert property (link_p(fall_q < 5'h10, dout_oe_o))
        else $error("output enable low inside frame");
    oe_release_a: assert property (@(posedge sclk_i) disable iff (!rstn_i || cs_n_i)
        fall_q == 5'h10 |-> !dout_oe_o) else $error("output still driven after last fall");
    lead_zero_a: assert property (link_p(fall_q == 5'h00, dout_o == 1'b0))
        else $error("first leading bit not zero");
    second_zero_a: assert property (link_p(fall_q == 5'h01, dout_o == 1'b0))
        else $error("second leading bit not zero");
    oe_idle_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cs_n_i |-> !dout_oe_o) else $error("output driven while deselected");
    start_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        awake_o && $fell(cs_n_i) |-> ##[1:6] conv_start_o) else $error("no conversion start");
    start_once_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        conv_start_o |=> !conv_start_o) else $error("start pulse too long");
    track_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(track_o) |-> !cs_n_i) else $error("hold entered while deselected");
    awake_excl_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        awake_o |-> !power_down_o) else $error("awake and powered down together");
    sleep_entry_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(power_down_o) |-> $past(awake_o)) else $error("power down not from awake");
    ref_on_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ref_on_o |-> ref_sel_o || $past(ref_sel_o)) else $error("reference on without bit");
    cover property (@(posedge clock_i) $rose(power_down_o));
    cover property (@(posedge clock_i) $rose(awake_o));
    cover property (@(posedge clock_i) conv_start_o);
endmodule
bind adc_serial_power_control adc_serial_checker chk (.clock_i(clock_i), .rstn_i(rstn_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .conv_start_o(conv_start_o), .track_o(track_o), .power_down_o(power_down_o),
    .ref_on_o(ref_on_o), .awake_o(awake_o), .ref_sel_o(ref_sel_o));
`default_nettype wire

/* dv/host_model.sv */
// Purpose: Host serial port driving frames into the converter
// Assumes: Serial clock period 48 ns, idle high, stopped between frames
// Notes:   Samples the output just before each falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic     sclk_o,
    output logic     cs_n_o,
    output logic     din_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, input int n, input logic hold,
                        output logic [15:0] rx);
        rx     = 16'h0000;
        cs_n_o = 1'b0;
        din_o  = w[15];
        #24;
        for (int k = 1; k <= n; k++)
        begin
            rx[16-k] = dout_oe_i ? dout_i : 1'bx;
            sclk_o   = 1'b0;
            #24;
            sclk_o = 1'b1;
            din_o  = (k < 16) ? w[15-k] : ~din_o;
            #24;
        end
        if (!hold)
            cs_n_o = 1'b1;
        // Released data line shows no stale value
        din_o = ~din_o;
    endtask
    task automatic cs_up();
        cs_n_o = 1'b1;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the converter serial port and power control
// Assumes: Auto and full wake counts shortened to 20 cycles; standby keeps STBY_WAKE_CYC
// Notes:   Host frames run on their own 48 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_serial_pkg::*;
    localparam int WAKE_SIM = 20;
    logic        clock, rstn, ce, sclk, cs_n, din, dout, dout_oe, conv_chan, conv_start;
    logic        track, power_down, ref_on, awake, res_inv, pm_hi, pm_lo, ref_sel, chan_sel;
    logic        r0h, r0l, r1h, r1l;
    logic [12:0] conv_data;
    logic [15:0] rx;
    logic [11:0] status;
    logic [1:0]  mode;
    int          wake, mismatches, checks_done, cycles;
    assign status = {track, awake, power_down, ref_on, pm_hi, pm_lo, ref_sel, chan_sel,
                     r0h, r0l, r1h, r1l};
    adc_serial_power_control #(.AUTO_WAKE_CYC(WAKE_SIM), .FULL_WAKE_CYC(WAKE_SIM)) uut (
        .clock_i(clock), .rstn_i(rstn), .ce_i(ce), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .conv_data_i(conv_data),
        .conv_chan_i(conv_chan), .conv_start_o(conv_start), .track_o(track),
        .power_down_o(power_down), .ref_on_o(ref_on), .awake_o(awake),
        .result_invalid_o(res_inv), .power_mode_hi_o(pm_hi), .power_mode_lo_o(pm_lo),
        .ref_sel_o(ref_sel), .chan_sel_o(chan_sel), .chan0_range_hi_o(r0h),
        .chan0_range_lo_o(r0l), .chan1_range_hi_o(r1h), .chan1_range_lo_o(r1l));
    host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
        .dout_oe_i(dout_oe));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [15:0] w, input int n, input logic hold);
        host.xfer(w, n, hold, rx);
        repeat (8) @(negedge clock);
    endtask
    task automatic wait_awake(input int lo, input int hi);
        int n;
        n = 0;
        while (awake !== 1'b1 && n <= hi)
        begin
            @(negedge clock);
            n++;
        end
        check({15'h0, n >= lo && n <= hi}, 16'h0001);
    endtask
    function automatic logic [15:0] ctl(input logic ch, input logic [1:0] pm, input logic rf);
        logic [11:0] c;
        c = 12'h000;
        c[CTRL_CHAN]  = ch;
        c[CTRL_PM_HI] = pm[1];
        c[CTRL_PM_LO] = pm[0];
        c[CTRL_REF]   = rf;
        return {WRITE_ON, ZERO_OK, SEL_CTRL, c, 1'b0};
    endfunction
    function automatic logic [15:0] rng(input logic [1:0] a, input logic [1:0] b);
        return {WRITE_ON, ZERO_OK, SEL_RANGE, a, 2'b00, b, 7'h00};
    endfunction
    initial
    begin
        rstn      = 1'b0;
        ce        = 1'b1;
        conv_data = 13'h1A5C;
        conv_chan = 1'b1;
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        check({4'h0, status}, 16'h0C00);
        frame(ctl(1'b1, PM_NORMAL, 1'b1), 16, 1'b0);
        check({4'h0, status}, 16'h0D30);
        check({15'h0, res_inv}, 16'h0001);
        conv_data = 13'h0123;
        conv_chan = 1'b0;
        frame(ctl(1'b0, PM_FULL, 1'b0) & 16'h7FFF, 16, 1'b0);
        check(rx, 16'h3A5C);
        check({4'h0, status}, 16'h0D30);
        check({15'h0, res_inv}, 16'h0000);
        $display("test control and word done");
        for (int c = 0; c < 4; c++)
        begin
            frame(rng(c[1:0], ~c[1:0]), 16, 1'b0);
            check({12'h0, r0h, r0l, r1h, r1l}, {12'h0, c[1:0], ~c[1:0]});
            if (c == 0)
                check(rx, 16'h0123);
        end
        frame(rng(2'h0, 2'h3), 10, 1'b0);
        check({12'h0, r0h, r0l, r1h, r1l}, 16'h000C);
        frame(rng(2'h0, 2'h3), 11, 1'b0);
        check({12'h0, r0h, r0l, r1h, r1l}, 16'h0003);
        frame(ctl(1'b0, PM_NORMAL, 1'b1), 14, 1'b0);
        check({15'h0, chan_sel}, 16'h0001);
        $display("test range and abort done");
        frame(ctl(1'b1, PM_FULL, 1'b0), 16, 1'b0);
        check({11'h0, power_down, awake, ref_on, pm_hi, pm_lo}, 16'h0013);
        frame(16'h0000, 16, 1'b0);
        check({15'h0, power_down}, 16'h0001);
        frame(ctl(1'b1, PM_NORMAL, 1'b1), 16, 1'b0);
        check({15'h0, awake}, 16'h0000);
        wait_awake(0, WAKE_SIM + 8);
        $display("test full shutdown done");
        for (int m = 0; m < 2; m++)
        begin
            mode = m ? PM_STBY : PM_AUTO;
            wake = m ? STBY_WAKE_CYC : WAKE_SIM;
            frame(ctl(1'b0, mode, 1'b1), 16, 1'b1);
            check({13'h0, power_down, track, ref_on}, {13'h0, 2'b10, m[0]});
            host.cs_up();
            repeat (6) @(negedge clock);
            check({15'h0, track}, 16'h0001);
            wait_awake(wake - 6, wake + 6);
            frame(16'h0000, 16, 1'b1);
            check({15'h0, power_down}, 16'h0001);
            host.cs_up();
            wait_awake(0, wake + 12);
        end
        frame(ctl(1'b0, PM_NORMAL, 1'b0), 16, 1'b0);
        check({14'h0, awake, power_down}, 16'h0002);
        $display("test auto modes done");
        final_report();
    end
endmodule
`default_nettype wire
